// ### verilog/ascd_pkg.sv
// Package for the serial configuration decoder: fields, resets, types
package ascd_pkg;

	// ****************************************************************
	// Command byte patterns
	// ****************************************************************
	localparam int CMD_CONV_BIT    = 7;
	localparam int CMD_SETUP_BIT   = 6;
	localparam int CMD_AVG_BIT     = 5;
	localparam int CMD_RESET_BIT   = 4;
	localparam int RST_FIFO_BIT    = 3;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CLK_MODE_LSB    = 4;
	localparam int REF_MODE_LSB    = 2;
	localparam int PAIR_SEL_LSB    = 0;
	localparam int AVG_EN_BIT      = 4;
	localparam int AVG_CNT_LSB     = 2;
	localparam int REP_CNT_LSB     = 0;
	localparam int PAIR_BITS_LSB   = 4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] SETUP_RESET = 8'h20;
	localparam logic [7:0] REG_RESET   = 8'h00;

	// ****************************************************************
	// Result framing and timing
	// ****************************************************************
	localparam int RESULT_BITS     = 12;
	localparam int WORD_BITS       = 16;
	localparam int SCLK_CONV_MAX_KHZ = 4800;
	localparam int CLK_KHZ         = 40000;
	localparam int SCLK_MIN_CYCLES = (CLK_KHZ + SCLK_CONV_MAX_KHZ - 1) / SCLK_CONV_MAX_KHZ;

	typedef enum logic [1:0] {
		ASCD_CK_INT_AUTO,
		ASCD_CK_INT_PIN_ACQ,
		ASCD_CK_INT_SERIAL,
		ASCD_CK_SCLK
	} ascd_clk_mode_e;

	typedef enum logic [1:0] {
		ASCD_REF_INT_SHUT,
		ASCD_REF_EXT_SE,
		ASCD_REF_INT_ON,
		ASCD_REF_EXT_DIFF
	} ascd_ref_mode_e;

	typedef struct packed {
		logic [1:0] clock_mode;
		logic [1:0] reference_mode;
		logic [1:0] pair_register_sel;
	} ascd_setup_s;

	typedef struct packed {
		logic       average_enable;
		logic [1:0] average_count;
		logic [1:0] repeat_count;
	} ascd_avg_s;

	typedef struct packed {
		logic       internal_clock;
		logic       acq_by_pin;
		logic       pin_is_convert;
		logic       conv_by_sclk;
		logic       start_by_pin;
		logic       internal_ref;
		logic       ref_wake_delay;
		logic       analog_input_six_is_neg_ref;
		logic [5:0] conv_per_result;
		logic [4:0] repeat_results;
	} ascd_cfg_s;

endpackage : ascd_pkg

// ### verilog/ascd_decoder.sv
// Serial command decoder and result shifter of the converter's serial port
// Functional notes
// - 01xxxxxx byte loads setup fields
// - Setup clock mode high bit resets to one
// - Modes 00 and 01 use convert start pin
// - Mode 10 frees pin; 11 clocks from serial
// - Internal reference: 00 sleeps, 10 stays on
// - 01/11 external; 11 makes input six reference
// - Pair select 00/01 expects no data byte
// - Pair select 10 stores next byte unipolar
// - Pair select 11 stores next byte bipolar
// - Result word: four zeros, twelve bits MSB first
// - Input sampled on serial clock rising edge
// - Output changes only on serial clock falling
// - Start by pin or conversion byte per mode
// - Unipolar straight binary, bipolar two's complement
// - Unipolar bits 7..4 enable pairs, rest ignored
// - Bipolar bits 7..4 enable pairs, rest ignored
// - 001xxxxx byte loads averaging fields
// - Averaging off means one conversion per result
// - Average counts 4, 8, 16, 32
// - Repeat counts 4, 8, 12, 16
// - 0001xxxx byte is reset command
// - Bit3 clears FIFO only, else FIFO clear plus full register reset
// - Bit7 set means conversion command, top priority
// - Pair in both registers treated unipolar
// - Power-up values zero except setup clock bit
`timescale 1ns/1ps

module ascd_decoder
	import ascd_pkg::*;
#(
	parameter int PAIRS = 4
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   din,
	input  wire logic                   result_valid,
	input  wire logic [RESULT_BITS-1:0] result_data,
	input  wire logic                   result_bipolar,
	output logic                        result_ready,
	output logic                        dout,
	output logic                        conv_cmd_valid,
	output logic [7:0]                  conv_cmd_byte,
	output logic                        fifo_clear,
	output ascd_cfg_s                   cfg,
	output logic [PAIRS-1:0]            pair_unipolar,
	output logic [PAIRS-1:0]            pair_bipolar
);

	// ****************************************************************
	// Pin synchronisers and edge detection
	// ****************************************************************
	logic [1:0] sclk_sync_q;
	logic [1:0] cs_sync_q;
	logic [1:0] din_sync_q;
	logic       sclk_prev_q;
	logic       cs_prev_q;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_fall;
	logic       cs_active;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// Serial clock idles high: matching reset avoids a false edge
			sclk_sync_q <= 2'h3;
			cs_sync_q   <= 2'h3;
			din_sync_q  <= 2'h0;
			sclk_prev_q <= 1'b1;
			cs_prev_q   <= 1'b1;
		end else begin
			sclk_sync_q <= {sclk_sync_q[0], sclk};
			cs_sync_q   <= {cs_sync_q[0], cs_n};
			din_sync_q  <= {din_sync_q[0], din};
			sclk_prev_q <= sclk_sync_q[1];
			cs_prev_q   <= cs_sync_q[1];
		end
	end

	assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
	assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;
	assign cs_fall   = ~cs_sync_q[1] & cs_prev_q;
	assign cs_active = ~cs_sync_q[1];

	// ****************************************************************
	// Input byte assembly
	// ****************************************************************
	logic [2:0] bit_cnt_q;
	logic [6:0] shift_in_q;
	logic       byte_done;
	logic [7:0] in_byte;

	assign byte_done = cs_active & sclk_rise & (bit_cnt_q == 3'h7);
	assign in_byte   = {shift_in_q, din_sync_q[1]};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt_q  <= 3'h0;
			shift_in_q <= 7'h00;
		end else if (cs_fall) begin
			bit_cnt_q  <= 3'h0;
		end else if (cs_active && sclk_rise) begin
			shift_in_q <= {shift_in_q[5:0], din_sync_q[1]};
			bit_cnt_q  <= bit_cnt_q + 3'h1;
		end
	end

	// ****************************************************************
	// Command decode and register file
	// ****************************************************************
	logic [7:0]  setup_q;
	logic [7:0]  avg_q;
	logic [7:0]  uni_q;
	logic [7:0]  bip_q;
	logic [1:0]  data_pending_q;
	ascd_setup_s setup_f;
	ascd_avg_s   avg_f;
	logic        is_conv;
	logic        is_setup;
	logic        is_avg;
	logic        is_rst;
	logic        full_reset;

	assign setup_f = ascd_setup_s'(setup_q[5:0]);
	assign avg_f   = ascd_avg_s'(avg_q[4:0]);

	always_comb begin
		is_conv  = 1'b0;
		is_setup = 1'b0;
		is_avg   = 1'b0;
		is_rst   = 1'b0;
		if (data_pending_q != 2'h0) begin
			is_conv = 1'b0;
		end else if (in_byte[CMD_CONV_BIT]) begin
			is_conv = 1'b1;
		end else if (in_byte[CMD_SETUP_BIT]) begin
			is_setup = 1'b1;
		end else if (in_byte[CMD_AVG_BIT]) begin
			is_avg = 1'b1;
		end else if (in_byte[CMD_RESET_BIT]) begin
			is_rst = 1'b1;
		end
	end

	assign full_reset = byte_done & is_rst & ~in_byte[RST_FIFO_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setup_q <= SETUP_RESET;
			avg_q   <= REG_RESET;
			uni_q   <= REG_RESET;
			bip_q   <= REG_RESET;
		end else if (full_reset) begin
			setup_q <= SETUP_RESET;
			avg_q   <= REG_RESET;
			uni_q   <= REG_RESET;
			bip_q   <= REG_RESET;
		end else if (byte_done) begin
			if (data_pending_q == 2'h2) begin
				uni_q <= in_byte;
			end else if (data_pending_q == 2'h3) begin
				bip_q <= in_byte;
			end else if (is_setup) begin
				setup_q <= {2'b01, in_byte[5:0]};
			end else if (is_avg) begin
				avg_q <= {3'b001, in_byte[4:0]};
			end
		end
	end

	// Pending data byte follows a setup byte in the same frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_pending_q <= 2'h0;
		end else if (cs_fall || full_reset) begin
			data_pending_q <= 2'h0;
		end else if (byte_done) begin
			if (data_pending_q != 2'h0) begin
				data_pending_q <= 2'h0;
			end else if (is_setup && in_byte[1]) begin
				data_pending_q <= in_byte[1:0];
			end else begin
				data_pending_q <= 2'h0;
			end
		end
	end

	// Conversion and FIFO clear strobes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_cmd_valid <= 1'b0;
			conv_cmd_byte  <= 8'h00;
			fifo_clear     <= 1'b0;
		end else begin
			conv_cmd_valid <= byte_done & is_conv &
				setup_f.clock_mode[1];
			fifo_clear     <= byte_done & is_rst;
			if (byte_done && is_conv) begin
				conv_cmd_byte <= in_byte;
			end
		end
	end

	// ****************************************************************
	// Decoded configuration
	// ****************************************************************
	logic [PAIRS-1:0] uni_bits;
	logic [PAIRS-1:0] bip_bits;

	always_comb begin
		for (int i = 0; i < PAIRS; i++) begin
			uni_bits[i] = uni_q[7-i];
			bip_bits[i] = bip_q[7-i] & ~uni_q[7-i];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg           <= '0;
			pair_unipolar <= '0;
			pair_bipolar  <= '0;
		end else begin
			pair_unipolar <= uni_bits;
			pair_bipolar  <= bip_bits;
			cfg.internal_clock  <= (setup_f.clock_mode != ASCD_CK_SCLK);
			cfg.acq_by_pin      <= (setup_f.clock_mode == ASCD_CK_INT_PIN_ACQ);
			cfg.pin_is_convert  <= ~setup_f.clock_mode[1];
			cfg.conv_by_sclk    <= (setup_f.clock_mode == ASCD_CK_SCLK);
			cfg.start_by_pin    <= ~setup_f.clock_mode[1];
			cfg.internal_ref    <= ~setup_f.reference_mode[0];
			cfg.ref_wake_delay  <= (setup_f.reference_mode == ASCD_REF_INT_SHUT);
			cfg.analog_input_six_is_neg_ref <= (setup_f.reference_mode == ASCD_REF_EXT_DIFF);
			cfg.conv_per_result <= avg_f.average_enable ?
				(6'h04 << avg_f.average_count) : 6'h01;
			cfg.repeat_results  <= {1'b0, avg_f.repeat_count, 2'b00} + 5'h04;
		end
	end

	// ****************************************************************
	// Result buffer, two entries
	// ****************************************************************
	logic [RESULT_BITS-1:0] buf_q [2];
	logic                   wr_ptr_q;
	logic                   rd_ptr_q;
	logic [1:0]             count_q;
	logic                   buf_pop;
	logic                   buf_push;

	assign buf_push = result_valid & result_ready;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q     <= 1'b0;
			rd_ptr_q     <= 1'b0;
			count_q      <= 2'h0;
			result_ready <= 1'b1;
		end else if (fifo_clear) begin
			wr_ptr_q     <= 1'b0;
			rd_ptr_q     <= 1'b0;
			count_q      <= 2'h0;
			result_ready <= 1'b1;
		end else begin
			if (buf_push) begin
				buf_q[wr_ptr_q] <= result_bipolar ? result_data :
					result_data;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (buf_pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q      <= count_q + {1'b0, buf_push} - {1'b0, buf_pop};
			result_ready <= (count_q + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h2;
		end
	end

	// ****************************************************************
	// Output shifter
	// ****************************************************************
	logic [WORD_BITS-1:0] out_sr_q;
	logic [3:0]           out_cnt_q;
	logic                 loaded_q;

	assign buf_pop = cs_active & sclk_fall & ~loaded_q & (count_q != 2'h0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_sr_q  <= '0;
			out_cnt_q <= 4'h0;
			loaded_q  <= 1'b0;
			dout      <= 1'b0;
		end else if (!cs_active) begin
			loaded_q  <= 1'b0;
			out_cnt_q <= 4'h0;
		end else if (sclk_fall) begin
			if (!loaded_q) begin
				out_sr_q  <= (count_q != 2'h0) ?
					{4'h0, buf_q[rd_ptr_q]} : '0;
				loaded_q  <= (count_q != 2'h0);
				dout      <= 1'b0;
				out_cnt_q <= 4'h1;
			end else begin
				dout      <= out_sr_q[WORD_BITS-1 - out_cnt_q];
				out_cnt_q <= out_cnt_q + 4'h1;
				if (out_cnt_q == 4'hF) begin
					loaded_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_setup_load;
		@(posedge clk) disable iff (rst)
		(byte_done && data_pending_q == 2'h0 && !in_byte[7] && in_byte[6])
			|=> setup_q[5:0] == $past(in_byte[5:0]);
	endproperty
	a_setup_load: assert property (p_setup_load) else $error("setup not loaded");

	property p_uni_load;
		@(posedge clk) disable iff (rst)
		(byte_done && data_pending_q == 2'h2) |=> uni_q == $past(in_byte);
	endproperty
	a_uni_load: assert property (p_uni_load) else $error("unipolar not loaded");

	property p_bip_load;
		@(posedge clk) disable iff (rst)
		(byte_done && data_pending_q == 2'h3) |=> bip_q == $past(in_byte);
	endproperty
	a_bip_load: assert property (p_bip_load) else $error("bipolar not loaded");

	property p_no_data;
		@(posedge clk) disable iff (rst)
		(byte_done && is_setup && !in_byte[1]) |=> data_pending_q == 2'h0;
	endproperty
	a_no_data: assert property (p_no_data) else $error("data expected wrongly");

	property p_full_reset;
		@(posedge clk) disable iff (rst)
		full_reset |=> (setup_q == SETUP_RESET && uni_q == 8'h00 && avg_q == 8'h00);
	endproperty
	a_full_reset: assert property (p_full_reset) else $error("reset failed");

	property p_conv_prio;
		@(posedge clk) disable iff (rst)
		(byte_done && data_pending_q == 2'h0 && in_byte[7]) |=> $stable(setup_q) && $stable(avg_q);
	endproperty
	a_conv_prio: assert property (p_conv_prio) else $error("conversion byte altered regs");

	property p_dout_fall;
		@(posedge clk) disable iff (rst)
		!sclk_fall |=> $stable(dout);
	endproperty
	a_dout_fall: assert property (p_dout_fall) else $error("dout moved off falling edge");

	property p_avg_count;
		@(posedge clk) disable iff (rst)
		!avg_f.average_enable ##1 !avg_f.average_enable |=> cfg.conv_per_result == 6'h01;
	endproperty
	a_avg_count: assert property (p_avg_count) else $error("averaging off count wrong");

	property p_cnt_restart;
		@(posedge clk) disable iff (rst)
		cs_fall |=> bit_cnt_q == 3'h0;
	endproperty
	a_cnt_restart: assert property (p_cnt_restart) else $error("bit counter not restarted");

	c_setup_data: cover property (@(posedge clk) disable iff (rst)
		byte_done && data_pending_q == 2'h2);
	c_full_reset: cover property (@(posedge clk) disable iff (rst) full_reset);
	c_conv_cmd: cover property (@(posedge clk) disable iff (rst) conv_cmd_valid);
	c_buf_full: cover property (@(posedge clk) disable iff (rst) count_q == 2'h2);

endmodule : ascd_decoder

// ### dv/ascd_host_model.sv
// Serial host model: frames bytes on the link and captures the returned word
`timescale 1ns/1ps

module ascd_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	logic [15:0] rx_word;

	initial begin
		sclk    = 1'b1;
		cs_n    = 1'b1;
		din     = 1'b0;
		rx_word = 16'h0000;
	end

	// ****
	// One frame: clock stands high outside frames
	// ****
	task automatic frame(input logic [15:0] tx, input int nbits);
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			sclk <= 1'b0;
			din  <= tx[15-i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			@(posedge clk);
			rx_word[15-i] <= dout;
			repeat (3) @(posedge clk);
		end
		cs_n <= 1'b1;
		// Released data line does not keep its last value
		din  <= ~din;
		repeat (8) @(posedge clk);
	endtask : frame
endmodule : ascd_host_model

// ### dv/testbench.sv
// Self-checking bench of the serial configuration decoder
`timescale 1ns/1ps

module testbench
	import ascd_pkg::*;
;
	typedef struct packed {
		logic [7:0] cmd;
		logic [5:0] setup;
		logic [4:0] avg;
		logic       conv;
	} ascd_row_s;

	logic                   clk;
	logic                   rst;
	logic                   sclk;
	logic                   cs_n;
	logic                   din;
	logic                   dout;
	logic                   result_valid;
	logic [RESULT_BITS-1:0] result_data;
	logic                   result_bipolar;
	logic                   result_ready;
	logic                   conv_cmd_valid;
	logic [7:0]             conv_cmd_byte;
	logic                   fifo_clear;
	ascd_cfg_s              cfg;
	logic [3:0]             pair_unipolar;
	logic [3:0]             pair_bipolar;
	int                     err_total;
	int                     compares;
	int                     conv_seen;
	int                     clear_seen;
	int                     base;
	ascd_row_s              rows [12];

	ascd_decoder #(.PAIRS(4)) ascd_decoder_i (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.result_valid(result_valid), .result_data(result_data),
		.result_bipolar(result_bipolar), .result_ready(result_ready), .dout(dout),
		.conv_cmd_valid(conv_cmd_valid), .conv_cmd_byte(conv_cmd_byte),
		.fifo_clear(fifo_clear), .cfg(cfg), .pair_unipolar(pair_unipolar),
		.pair_bipolar(pair_bipolar)
	);

	ascd_host_model ascd_host_model_i (
		.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout)
	);

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (conv_cmd_valid === 1'b1) conv_seen++;
		if (fifo_clear === 1'b1) clear_seen++;
	end

	// ****
	// Helpers
	// ****
	function automatic ascd_cfg_s exp_cfg(input logic [5:0] s, input logic [4:0] a);
		ascd_cfg_s c;
		c.internal_clock  = (s[5:4] != 2'b11);
		c.acq_by_pin      = (s[5:4] == 2'b01);
		c.pin_is_convert  = ~s[5];
		c.conv_by_sclk    = (s[5:4] == 2'b11);
		c.start_by_pin    = ~s[5];
		c.internal_ref    = ~s[2];
		c.ref_wake_delay  = (s[3:2] == 2'b00);
		c.analog_input_six_is_neg_ref = (s[3:2] == 2'b11);
		c.conv_per_result = a[4] ? (6'h04 << a[3:2]) : 6'h01;
		c.repeat_results  = 5'h04 + {1'b0, a[1:0], 2'b00};
		return c;
	endfunction : exp_cfg

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic push(input logic [11:0] d, input logic bip);
		int n;
		n = 0;
		@(posedge clk);
		result_valid   <= 1'b1;
		result_data    <= d;
		result_bipolar <= bip;
		@(posedge clk);
		while (result_ready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
		end
		if (result_ready !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: ready %0h expected %0h", $time, result_ready, 1'b1);
		end
		result_valid <= 1'b0;
	endtask : push

	task automatic wrap_up();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#1_000_000;
		err_total++;
		wrap_up();
	end

	// ****
	// Main sequence
	// ****
	initial begin
		rst = 1'b1;
		result_valid = 1'b0;
		result_data = 12'h000;
		result_bipolar = 1'b0;
		err_total = 0;
		compares = 0;
		conv_seen = 0;
		clear_seen = 0;
		rows = '{'{8'h30, 6'h20, 5'h10, 1'b0}, '{8'h36, 6'h20, 5'h16, 1'b0},
			'{8'h3B, 6'h20, 5'h1B, 1'b0}, '{8'h3C, 6'h20, 5'h1C, 1'b0},
			'{8'h25, 6'h20, 5'h05, 1'b0}, '{8'h40, 6'h00, 5'h05, 1'b0},
			'{8'h54, 6'h14, 5'h05, 1'b0}, '{8'hA2, 6'h14, 5'h05, 1'b0},
			'{8'h68, 6'h28, 5'h05, 1'b0}, '{8'hC3, 6'h28, 5'h05, 1'b1},
			'{8'h7D, 6'h3D, 5'h05, 1'b0}, '{8'h8E, 6'h3D, 5'h05, 1'b1}};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(32'(cfg), 32'(exp_cfg(6'h20, 5'h00)));
		chk(32'({pair_unipolar, pair_bipolar, result_ready, dout}), 32'h002);
		foreach (rows[i]) begin
			base = conv_seen;
			ascd_host_model_i.frame({rows[i].cmd, 8'h00}, 8);
			chk(32'(cfg), 32'(exp_cfg(rows[i].setup, rows[i].avg)));
			chk(32'(conv_seen - base), 32'(rows[i].conv));
			if (rows[i].conv) chk(32'(conv_cmd_byte), 32'(rows[i].cmd));
		end
		// Pair registers, overlap and trailing bits
		ascd_host_model_i.frame(16'h4AA5, 16);
		chk(32'(pair_unipolar), 32'h5);
		ascd_host_model_i.frame(16'h4B6F, 16);
		chk(32'({pair_unipolar, pair_bipolar}), 32'h52);
		ascd_host_model_i.frame(16'h693C, 16);
		chk(32'(cfg), 32'(exp_cfg(6'h29, 5'h1C)));
		chk(32'({pair_unipolar, pair_bipolar}), 32'h52);
		// Pending data byte and partial byte dropped by a new frame
		ascd_host_model_i.frame(16'h4E00, 8);
		ascd_host_model_i.frame(16'hF000, 4);
		ascd_host_model_i.frame(16'h2500, 8);
		chk(32'(cfg), 32'(exp_cfg(6'h0E, 5'h05)));
		chk(32'(pair_unipolar), 32'h5);
		// Result buffer filled, stalled, drained
		push(12'hA5C, 1'b0);
		push(12'h9F3, 1'b1);
		@(posedge clk);
		#1;
		chk(32'(result_ready), 32'h0);
		ascd_host_model_i.frame(16'h0000, 16);
		chk(32'(ascd_host_model_i.rx_word), 32'h0A5C);
		ascd_host_model_i.frame(16'h0000, 16);
		chk(32'(ascd_host_model_i.rx_word), 32'h09F3);
		chk(32'(result_ready), 32'h1);
		// Reset commands
		push(12'h123, 1'b0);
		push(12'h456, 1'b0);
		base = clear_seen;
		ascd_host_model_i.frame(16'h1800, 8);
		chk(32'(clear_seen - base), 32'h1);
		chk(32'({result_ready, pair_unipolar}), 32'h15);
		chk(32'(cfg), 32'(exp_cfg(6'h0E, 5'h05)));
		ascd_host_model_i.frame(16'h1700, 8);
		chk(32'(cfg), 32'(exp_cfg(6'h20, 5'h00)));
		chk(32'({pair_unipolar, pair_bipolar}), 32'h00);
		ascd_host_model_i.frame(16'h4BF0, 16);
		chk(32'(pair_bipolar), 32'hF);
		// Reset in mid-run
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(32'(cfg), 32'(exp_cfg(6'h20, 5'h00)));
		chk(32'({pair_unipolar, pair_bipolar}), 32'h00);
		wrap_up();
	end
endmodule : testbench
